// file: shared/tdmb_pkg.sv
// constants and carrier types for the per-stream pattern test logic
// assumes the host port runs on the same clock as the test logic
package tdmb_pkg;

    localparam int unsigned NSTREAM = 16;
    localparam int unsigned NCHAN   = 256;
    localparam int unsigned ADDR_W  = 14;
    localparam int unsigned DATA_W  = 16;
    localparam int unsigned BCNT_W  = 11;
    localparam int unsigned LFSR_W  = 15;

    // word addresses on the host port
    localparam logic [13:0] ADDR_MODE     = 14'h0000;
    localparam logic [9:0]  ADDR_CTRL_HI  = 10'h001;
    localparam logic [9:0]  ADDR_START_HI = 10'h002;
    localparam logic [9:0]  ADDR_LEN_HI   = 10'h003;
    localparam logic [9:0]  ADDR_ERR_HI   = 10'h004;
    localparam logic [1:0]  ADDR_CM_HI    = 2'h1;

    // field positions
    localparam int unsigned MODE_RX_EN_BIT = 5;
    localparam int unsigned MODE_TX_EN_BIT = 4;
    localparam int unsigned CTRL_CLR_BIT   = 1;
    localparam int unsigned CTRL_EN_BIT    = 0;
    localparam int unsigned CM_SPECIAL_BIT = 0;
    localparam int unsigned START_W        = 8;
    localparam int unsigned LEN_W          = 9;
    localparam int unsigned CM_W           = 3;

    // encodings and reset values
    localparam logic [1:0]        PCC_BER     = 2'h2;
    localparam logic [15:0]       ERR_MAX     = 16'hFFFF;
    localparam logic [15:0]       ERR_RST     = 16'h0000;
    localparam logic [LFSR_W-1:0] LFSR_SEED   = 15'h7FFF;
    localparam logic [8:0]        LEN_RST     = 9'h001;
    localparam logic [7:0]        START_RST   = 8'h00;
    localparam logic [2:0]        CM_RST      = 3'h0;

    typedef struct packed {
        logic              cs;
        logic              rd;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } tdmb_req_t;

    typedef struct packed {
        logic              rdy;
        logic [DATA_W-1:0] rdata;
    } tdmb_rsp_t;

endpackage

// file: verilog/tdmb_lane.sv
// one stream's pattern generator, self-synchronising checker and error counter
// assumes tick, tx_on and rx_on come from the same clock domain
`timescale 1ns/1ps
module tdmb_lane
    import tdmb_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        tx_on,
    input  wire logic        rx_on,
    input  wire logic        rx_bit,
    input  wire logic        clear,
    output logic             tx_fb,
    output logic [15:0]      err_count
);
    logic [LFSR_W-1:0] tx_lfsr_r, tx_lfsr_nxt;
    logic [LFSR_W-1:0] rx_hist_r, rx_hist_nxt;
    logic [15:0]       err_r, err_nxt;
    logic              rx_pred;
    logic              miss;

    // x^15 + x^14 + 1, 2^15-1 sequence
    assign tx_fb   = tx_lfsr_r[14] ^ tx_lfsr_r[13];
    // receiver predicts from the last 15 received bits, so it locks on its own
    assign rx_pred = rx_hist_r[14] ^ rx_hist_r[13];
    assign miss    = rx_on && (rx_bit != rx_pred);

    always_comb begin
        tx_lfsr_nxt = tx_lfsr_r;
        rx_hist_nxt = rx_hist_r;
        err_nxt     = err_r;
        if (tx_on) begin
            tx_lfsr_nxt = {tx_lfsr_r[13:0], tx_fb};
        end
        if (rx_on) begin
            rx_hist_nxt = {rx_hist_r[13:0], rx_bit};
        end
        // a mismatch in the clearing cycle still counts
        if (clear) begin
            err_nxt = miss ? 16'h0001 : ERR_RST;
        end else if (miss && err_r != ERR_MAX) begin
            err_nxt = err_r + 16'h0001;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_lfsr_r <= LFSR_SEED;
            rx_hist_r <= LFSR_SEED;
            err_r     <= ERR_RST;
        end else if (ce) begin
            tx_lfsr_r <= tx_lfsr_nxt;
            rx_hist_r <= rx_hist_nxt;
            err_r     <= err_nxt;
        end
    end

    assign err_count = err_r;
endmodule

// file: verilog/tdmb_tester.sv
// pattern test logic for sixteen TDM streams, with host registers
// assumes host port on clk; serial side (link clock, frame, data) asynchronous
`timescale 1ns/1ps
module tdmb_tester
    import tdmb_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    input  wire tdmb_pkg::tdmb_req_t  host_req,
    output tdmb_pkg::tdmb_rsp_t       host_rsp,
    input  wire logic                 link_clk,
    input  wire logic                 frame_pulse,
    input  wire logic [15:0]          rx_serial,
    input  wire logic [15:0]          switched_data,
    output logic [15:0]               tx_serial
);
    import tdmb_pkg::*;

    // synchronisers
    logic              lck_s1_r, lck_s2_r, lck_s3_r;
    logic              fp_s1_r, fp_s2_r;
    logic [15:0]       rx_s1_r, rx_s2_r;

    // frame position
    logic [BCNT_W-1:0] bcnt_r, bcnt_nxt;
    logic              tick;

    // host-visible state
    logic              rx_all_en_r, rx_all_en_nxt;
    logic              tx_all_en_r, tx_all_en_nxt;
    logic [15:0]       rx_en_r, rx_en_nxt;
    logic [7:0]        start_r [NSTREAM];
    logic [7:0]        start_nxt [NSTREAM];
    logic [8:0]        len_r [NSTREAM];
    logic [8:0]        len_nxt [NSTREAM];
    logic [2:0]        cm_r [NSTREAM][NCHAN];
    logic [2:0]        cm_nxt [NSTREAM][NCHAN];
    tdmb_rsp_t         rsp_r, rsp_nxt;
    logic [15:0]       tx_r, tx_nxt;

    logic [15:0]       clr;
    logic [15:0]       tx_on;
    logic [15:0]       rx_on;
    logic [15:0]       tx_fb;
    logic [15:0]       err_cnt [NSTREAM];

    logic              wr_hit, rd_hit;
    logic [9:0]        a_hi;
    logic [3:0]        a_lo;
    logic [7:0]        tx_ch, rx_ch;

    assign tick   = lck_s2_r & ~lck_s3_r;
    assign wr_hit = host_req.cs & host_req.wr;
    assign rd_hit = host_req.cs & host_req.rd;
    assign a_hi   = host_req.addr[13:4];
    assign a_lo   = host_req.addr[3:0];
    // receive samples the bit of the current position, transmit the next one
    assign rx_ch  = bcnt_r[10:3];
    assign tx_ch  = bcnt_nxt[10:3];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lck_s1_r <= 1'b0;
            lck_s2_r <= 1'b0;
            lck_s3_r <= 1'b0;
            fp_s1_r  <= 1'b0;
            fp_s2_r  <= 1'b0;
            rx_s1_r  <= 16'h0000;
            rx_s2_r  <= 16'h0000;
        end else if (ce) begin
            lck_s1_r <= link_clk;
            lck_s2_r <= lck_s1_r;
            lck_s3_r <= lck_s2_r;
            fp_s1_r  <= frame_pulse;
            fp_s2_r  <= fp_s1_r;
            rx_s1_r  <= rx_serial;
            rx_s2_r  <= rx_s1_r;
        end
    end

    // bit position within the frame, restarted by the frame pulse
    always_comb begin
        bcnt_nxt = bcnt_r;
        if (tick) begin
            bcnt_nxt = fp_s2_r ? '0 : bcnt_r + 11'h001;
        end
    end

    // host register writes and reads
    always_comb begin
        rx_all_en_nxt = rx_all_en_r;
        tx_all_en_nxt = tx_all_en_r;
        rx_en_nxt     = rx_en_r;
        start_nxt     = start_r;
        len_nxt       = len_r;
        cm_nxt        = cm_r;
        clr           = 16'h0000;
        rsp_nxt.rdy   = rd_hit | wr_hit;
        rsp_nxt.rdata = 16'h0000;
        if (wr_hit) begin
            if (host_req.addr == ADDR_MODE) begin
                rx_all_en_nxt = host_req.wdata[MODE_RX_EN_BIT];
                tx_all_en_nxt = host_req.wdata[MODE_TX_EN_BIT];
            end
            if (a_hi == ADDR_CTRL_HI) begin
                rx_en_nxt[a_lo] = host_req.wdata[CTRL_EN_BIT];
                clr[a_lo]       = host_req.wdata[CTRL_CLR_BIT];
            end
            if (a_hi == ADDR_START_HI) begin
                start_nxt[a_lo] = host_req.wdata[START_W-1:0];
            end
            if (a_hi == ADDR_LEN_HI) begin
                len_nxt[a_lo] = host_req.wdata[LEN_W-1:0];
            end
            // error count has no write path
            if (host_req.addr[13:12] == ADDR_CM_HI) begin
                cm_nxt[host_req.addr[11:8]][host_req.addr[7:0]] = host_req.wdata[CM_W-1:0];
            end
        end
        if (rd_hit) begin
            if (host_req.addr == ADDR_MODE) begin
                rsp_nxt.rdata[MODE_RX_EN_BIT] = rx_all_en_r;
                rsp_nxt.rdata[MODE_TX_EN_BIT] = tx_all_en_r;
            end
            if (a_hi == ADDR_CTRL_HI) begin
                rsp_nxt.rdata[CTRL_EN_BIT] = rx_en_r[a_lo];
            end
            if (a_hi == ADDR_START_HI) begin
                rsp_nxt.rdata[START_W-1:0] = start_r[a_lo];
            end
            if (a_hi == ADDR_LEN_HI) begin
                rsp_nxt.rdata[LEN_W-1:0] = len_r[a_lo];
            end
            if (a_hi == ADDR_ERR_HI) begin
                rsp_nxt.rdata = err_cnt[a_lo];
            end
            if (host_req.addr[13:12] == ADDR_CM_HI) begin
                rsp_nxt.rdata[CM_W-1:0] = cm_r[host_req.addr[11:8]][host_req.addr[7:0]];
            end
        end
    end

    // per-stream windows and output selection
    always_comb begin
        tx_nxt = tx_r;
        for (int n = 0; n < NSTREAM; n++) begin
            // pattern only where the special bit and the BER control code meet
            tx_on[n] = tick && tx_all_en_r
                       && cm_r[n][tx_ch][CM_SPECIAL_BIT]
                       && (cm_r[n][tx_ch][2:1] == PCC_BER);
            // window [start, start+len); wider arithmetic avoids wrap at channel 255
            rx_on[n] = tick && rx_all_en_r && rx_en_r[n]
                       && ({1'b0, rx_ch} >= {1'b0, start_r[n]})
                       && ({2'b00, rx_ch} < ({2'b00, start_r[n]} + {1'b0, len_r[n]}))
                       && !fp_s2_r;
            if (tick) begin
                tx_nxt[n] = tx_on[n] ? tx_fb[n] : switched_data[n];
            end
        end
    end

    // one lane per stream
    for (genvar g = 0; g < NSTREAM; g++) begin : g_lane
        tdmb_lane u_lane (
            .clk       (clk),
            .rst       (rst),
            .ce        (ce),
            .tx_on     (tx_on[g]),
            .rx_on     (rx_on[g]),
            .rx_bit    (rx_s2_r[g]),
            .clear     (clr[g]),
            .tx_fb     (tx_fb[g]),
            .err_count (err_cnt[g])
        );
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bcnt_r      <= '0;
            rx_all_en_r <= 1'b0;
            tx_all_en_r <= 1'b0;
            rx_en_r     <= 16'h0000;
            rsp_r       <= '0;
            tx_r        <= 16'h0000;
            for (int n = 0; n < NSTREAM; n++) begin
                start_r[n] <= START_RST;
                len_r[n]   <= LEN_RST;
                for (int c = 0; c < NCHAN; c++) begin
                    cm_r[n][c] <= CM_RST;
                end
            end
        end else if (ce) begin
            bcnt_r      <= bcnt_nxt;
            rx_all_en_r <= rx_all_en_nxt;
            tx_all_en_r <= tx_all_en_nxt;
            rx_en_r     <= rx_en_nxt;
            rsp_r       <= rsp_nxt;
            tx_r        <= tx_nxt;
            start_r     <= start_nxt;
            len_r       <= len_nxt;
            cm_r        <= cm_nxt;
        end
    end

    assign host_rsp  = rsp_r;
    assign tx_serial = tx_r;
endmodule

// file: tb/tdmb_tester_sva.sv
// host port checks for the pattern test logic
// assumes host port and checker share clk; serial side not watched here
`timescale 1ns/1ps
module tdmb_tester_sva
    import tdmb_pkg::*;
(
    input wire logic                clk,
    input wire logic                rst,
    input wire logic                ce,
    input wire tdmb_pkg::tdmb_req_t host_req,
    input wire tdmb_pkg::tdmb_rsp_t host_rsp
);
    logic       acc, rd_a, wr_a;
    logic [1:0] mode_r, mode_nxt;
    logic [7:0] start_r [16];
    logic [7:0] start_nxt [16];
    logic [8:0] len_r [16];
    logic [8:0] len_nxt [16];
    assign acc  = ce && host_req.cs && (host_req.rd || host_req.wr);
    assign rd_a = acc && host_req.rd;
    assign wr_a = acc && host_req.wr;
    // shadow of the mode, start and length fields, to judge read data
    always_comb begin
        mode_nxt  = mode_r;
        start_nxt = start_r;
        len_nxt   = len_r;
        if (wr_a && host_req.addr == ADDR_MODE) mode_nxt = host_req.wdata[5:4];
        if (wr_a && host_req.addr[13:4] == ADDR_START_HI)
            start_nxt[host_req.addr[3:0]] = host_req.wdata[7:0];
        if (wr_a && host_req.addr[13:4] == ADDR_LEN_HI)
            len_nxt[host_req.addr[3:0]] = host_req.wdata[8:0];
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_r  <= 2'h0;
            start_r <= '{default: START_RST};
            len_r   <= '{default: LEN_RST};
        end else begin
            mode_r  <= mode_nxt;
            start_r <= start_nxt;
            len_r   <= len_nxt;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_RDY_ACCEPT: assert property (acc |=> host_rsp.rdy)
        else $error("no ready after access");
    AST_RDY_IDLE: assert property ((ce && !acc) |=> !host_rsp.rdy)
        else $error("ready without access");
    AST_WR_RDATA_ZERO: assert property (wr_a |=> host_rsp.rdata == 16'h0000)
        else $error("write returned data");
    AST_MODE_READBACK: assert property ((rd_a && host_req.addr == ADDR_MODE)
        |=> host_rsp.rdata[5:4] == mode_r) else $error("mode enables wrong");
    AST_START_READBACK: assert property ((rd_a && host_req.addr[13:4] == ADDR_START_HI)
        |=> host_rsp.rdata == {8'h00, start_r[$past(host_req.addr[3:0])]})
        else $error("start channel wrong");
    AST_LEN_READBACK: assert property ((rd_a && host_req.addr[13:4] == ADDR_LEN_HI)
        |=> host_rsp.rdata == {7'h00, len_r[$past(host_req.addr[3:0])]})
        else $error("length wrong");
    AST_CTRL_CLR_READ0: assert property ((rd_a && host_req.addr[13:4] == ADDR_CTRL_HI)
        |=> !host_rsp.rdata[CTRL_CLR_BIT]) else $error("clear bit not self clearing");
    AST_CM_HIGH_ZERO: assert property ((rd_a && host_req.addr[13:12] == ADDR_CM_HI)
        |=> host_rsp.rdata[15:3] == 13'h0000) else $error("unstored memory bits set");
    AST_ERR_CLEAR: assert property ((wr_a && host_req.addr[13:4] == ADDR_CTRL_HI
        && host_req.wdata[CTRL_CLR_BIT]) ##2 (rd_a && host_req.addr[13:4] == ADDR_ERR_HI
        && host_req.addr[3:0] == $past(host_req.addr[3:0], 2))
        |=> host_rsp.rdata <= 16'h0001) else $error("error count not cleared");
endmodule
bind tdmb_tester tdmb_tester_sva u_tdmb_tester_sva (.clk(clk), .rst(rst), .ce(ce),
    .host_req(host_req), .host_rsp(host_rsp));

// file: tb/tdmb_link_model.sv
// far side of all sixteen streams: free-running link clock, frame pulse, loopback
// assumes a fixed short frame; the link clock never stops
`timescale 1ns/1ps
module tdmb_link_model #(
    parameter int FRAME_BITS = 512
) (
    output logic              link_clk,
    output logic              frame_pulse,
    output logic [15:0]       rx_serial,
    input  wire logic [15:0]  tx_serial,
    input  wire logic         err_on
);
    int cnt;
    initial begin
        link_clk    = 1'b0;
        frame_pulse = 1'b0;
        cnt         = 0;
        forever #24 link_clk = ~link_clk;
    end
    // pulse set on the falling edge so the next rising edge marks bit 0
    always @(negedge link_clk) begin
        frame_pulse <= (cnt == FRAME_BITS - 1);
        cnt         <= (cnt == FRAME_BITS - 1) ? 0 : cnt + 1;
    end
    // same channels back on the same stream; inversion only when commanded
    assign rx_serial = tx_serial ^ {16{err_on}};
endmodule

// file: tb/testbench.sv
// self-checking bench for the pattern test logic with looped-back streams
// assumes the link model frame of 512 bits, about 4916 clocks
`timescale 1ns/1ps
module testbench;
    import tdmb_pkg::*;
    localparam int FRAME_CLK = 4916;
    logic        clk, rst, ce, err_on, link_clk, frame_pulse, sw_hold;
    logic [15:0] rx_serial, switched_data, tx_serial, rd_v;
    tdmb_req_t   host_req;
    tdmb_rsp_t   host_rsp;
    int          err_total, n_tests;
    logic [3:0]  s;
    int          st, len;

    tdmb_tester u_tdmb_tester (.clk(clk), .rst(rst), .ce(ce), .host_req(host_req),
        .host_rsp(host_rsp), .link_clk(link_clk), .frame_pulse(frame_pulse),
        .rx_serial(rx_serial), .switched_data(switched_data), .tx_serial(tx_serial));
    tdmb_link_model u_tdmb_link_model (.link_clk(link_clk), .frame_pulse(frame_pulse),
        .rx_serial(rx_serial), .tx_serial(tx_serial), .err_on(err_on));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // frozen on demand so the pass-through path can be compared
    always @(posedge clk) if (!sw_hold) switched_data <= 16'($urandom);

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // entered at a rising edge; strobe lasts one cycle, answer taken at the
    // rising edge where rdy is sampled high, which is also where it returns
    task automatic bus(logic w, logic [13:0] a, logic [15:0] d);
        int i;
        host_req <= '{cs: 1'b1, rd: !w, wr: w, addr: a, wdata: d};
        @(posedge clk);
        host_req <= '0;
        for (i = 0; i < 4; i++) begin
            @(posedge clk);
            if (host_rsp.rdy === 1'b1) break;
        end
        if (i == 4) begin
            err_total++;
            $display("MISMATCH rdy expected 1 seen 0");
            end_sim();
        end
        rd_v = host_rsp.rdata;
    endtask
    task automatic rd(logic [13:0] a, logic [15:0] e, string nm);
        bus(1'b0, a, 16'h0000);
        chk(nm, e, rd_v);
    endtask
    task automatic frames(int n);
        repeat (n * FRAME_CLK) @(posedge clk);
    endtask
    // pattern entry inside the run, plain switching elsewhere
    function automatic logic [15:0] cm_word(int c);
        return (c >= st && c < st + len) ? 16'hFFFD : 16'hFFF8;
    endfunction
    // only the low three bits of an entry are kept
    function automatic logic [15:0] cm_read(logic [15:0] w);
        return w & 16'h0007;
    endfunction

    initial begin
        rst = 1'b1; ce = 1'b1; err_on = 1'b0; host_req = '0; switched_data = 16'h0000;
        sw_hold = 1'b0;
        err_total = 0; n_tests = 0;
        void'($urandom(32'hCCDD));
        s = 4'($urandom_range(15));
        st = $urandom_range(40);
        len = $urandom_range(16, 1);
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(ADDR_MODE, 16'h0000, "mode_rst");
        rd({ADDR_START_HI, s}, 16'h0000, "start_rst");
        rd({ADDR_LEN_HI, s}, 16'h0001, "len_rst");
        rd({ADDR_ERR_HI, s}, 16'h0000, "err_rst");
        bus(1'b1, {ADDR_ERR_HI, s}, 16'($urandom) | 16'h0001);
        rd({ADDR_ERR_HI, s}, 16'h0000, "err_ro");
        rd(14'h0050, 16'h0000, "unmapped");
        bus(1'b1, {ADDR_START_HI, s}, 16'hFF00 | 16'(st));
        rd({ADDR_START_HI, s}, 16'(st), "start");
        bus(1'b1, {ADDR_LEN_HI, s}, 16'hFE00 | 16'(len));
        rd({ADDR_LEN_HI, s}, 16'(len), "len");
        // transmitters off: every output must repeat the switched bits
        sw_hold <= 1'b1;
        repeat (30) @(posedge clk);
        chk("passthru", switched_data, tx_serial);
        sw_hold <= 1'b0;
        $display("test registers done");
        for (int c = 0; c < 64; c++)
            bus(1'b1, {ADDR_CM_HI, s, 8'(c)}, cm_word(c));
        rd({ADDR_CM_HI, s, 8'(st)}, cm_read(cm_word(st)), "cm");
        bus(1'b1, ADDR_MODE, 16'h0030);
        frames(2);
        bus(1'b1, {ADDR_CTRL_HI, s}, 16'h0003);
        rd({ADDR_CTRL_HI, s}, 16'h0001, "ctrl");
        frames(2);
        // receiver locks on its own input, so early errors are flushed here
        bus(1'b1, {ADDR_CTRL_HI, s}, 16'h0003);
        rd({ADDR_ERR_HI, s}, 16'h0000, "err_after_clr");
        frames(2);
        rd({ADDR_ERR_HI, s}, 16'h0000, "err_clean");
        $display("test loopback done");
        err_on <= 1'b1;
        frames(1);
        err_on <= 1'b0;
        frames(1);
        bus(1'b0, {ADDR_ERR_HI, s}, 16'h0000);
        chk("err_range", 16'h0001, {15'h0000, rd_v > 0 && rd_v <= 16'(len * 16 + 16)});
        bus(1'b1, {ADDR_CTRL_HI, s}, 16'h0000);
        bus(1'b0, {ADDR_ERR_HI, s}, 16'h0000);
        err_on <= 1'b1;
        frames(1);
        err_on <= 1'b0;
        rd({ADDR_ERR_HI, s}, rd_v, "err_hold");
        bus(1'b1, {ADDR_CTRL_HI, s}, 16'h0002);
        rd({ADDR_ERR_HI, s}, 16'h0000, "err_clear");
        $display("test errors done");
        bus(1'b1, ADDR_MODE, 16'h0010);
        bus(1'b1, {ADDR_CTRL_HI, s}, 16'h0001);
        err_on <= 1'b1;
        frames(1);
        err_on <= 1'b0;
        rd({ADDR_ERR_HI, s}, 16'h0000, "rx_global_off");
        $display("test global enable done");
        // reset in mid-run must bring back the defaults
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(ADDR_MODE, 16'h0000, "mode_rerst");
        rd({ADDR_LEN_HI, s}, 16'h0001, "len_rerst");
        $display("test mid-run reset done");
        end_sim();
    end
endmodule
